// ### rtl/tsc_pkg.sv
// Constants shared by the tile status and configuration register bank
package tsc_pkg;

   // -------------------------------------------------------------------
   // Widths
   // -------------------------------------------------------------------
   localparam int unsigned PS_NUM_W = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned CNT_W    = 16;
   localparam int unsigned NUM_OSC  = 4;
   localparam int unsigned SSR_W    = 11;

   // -------------------------------------------------------------------
   // Processor-status register numbers
   // -------------------------------------------------------------------
   localparam logic [7:0] REG_BOOT_STATUS = 8'h03;
   localparam logic [7:0] REG_SECURITY    = 8'h05;
   localparam logic [7:0] REG_OSC_CTRL    = 8'h06;
   localparam logic [7:0] REG_TILE_CELL   = 8'h07;
   localparam logic [7:0] REG_TILE_WIRE   = 8'h08;
   localparam logic [7:0] REG_PERI_CELL   = 8'h09;
   localparam logic [7:0] REG_PERI_WIRE   = 8'h0A;
   localparam logic [7:0] REG_RAM_SIZE    = 8'h0C;
   localparam logic [7:0] REG_DBG_SSR     = 8'h10;
   localparam logic [7:0] REG_DBG_SPC     = 8'h11;

   // -------------------------------------------------------------------
   // Boot status fields
   // -------------------------------------------------------------------
   localparam int unsigned BOOT_PLL_LSB   = 0;
   localparam int unsigned BOOT_PLL_W     = 2;
   localparam int unsigned BOOT_JTAG_BIT  = 2;
   localparam int unsigned BOOT_RAM_BIT   = 3;
   localparam int unsigned BOOT_SKIP_BIT  = 4;
   localparam int unsigned BOOT_C1OFF_BIT = 5;
   localparam int unsigned BOOT_OVR_BIT   = 8;
   localparam int unsigned BOOT_PNUM_LSB  = 16;
   localparam int unsigned BOOT_PNUM_W    = 8;

   // -------------------------------------------------------------------
   // Security configuration fields
   // -------------------------------------------------------------------
   localparam int unsigned SEC_TAP_BIT    = 0;
   localparam int unsigned SEC_JCFG_BIT   = 4;
   localparam int unsigned SEC_OTPB_BIT   = 5;
   localparam int unsigned SEC_RED_BIT    = 7;
   localparam int unsigned SEC_SECT_LSB   = 8;
   localparam int unsigned SEC_SECT_W     = 4;
   localparam int unsigned SEC_ALL_BIT    = 12;
   localparam int unsigned SEC_GDBG_BIT   = 14;
   localparam int unsigned SEC_WLOCK_BIT  = 31;
   localparam logic [31:0] SEC_WMASK      = 32'h8000_5FB1;
   localparam logic [31:0] SEC_RESET      = 32'h0000_0000;

   // -------------------------------------------------------------------
   // Oscillator control and counters
   // -------------------------------------------------------------------
   localparam int unsigned OSC_PERI_BIT   = 0;
   localparam int unsigned OSC_CORE_BIT   = 1;
   localparam logic [1:0]  OSC_CTRL_RESET = 2'h0;
   localparam logic [15:0] OSC_CNT_RESET  = 16'h0000;

   // -------------------------------------------------------------------
   // RAM size and debug capture
   // -------------------------------------------------------------------
   localparam int unsigned RAM_SIZE_LSB   = 2;
   localparam int unsigned SSR_DIRO_BIT   = 8;
   localparam logic [10:0] SSR_WMASK      = 11'h6DF;
   localparam logic [10:0] SSR_RESET      = 11'h000;
   localparam logic [31:0] SPC_RESET      = 32'h0000_0000;

endpackage

// ### rtl/tsc_osc_if.sv
// Bundle between the register bank and the ring oscillator counters
`timescale 1ns/1ps
interface tsc_osc_if;
   logic [tsc_pkg::NUM_OSC-1:0]                     run;
   logic [tsc_pkg::NUM_OSC-1:0]                     tick;
   logic [tsc_pkg::NUM_OSC-1:0][tsc_pkg::CNT_W-1:0] count;

   // Register bank side
   modport ctl (output run, output tick, input count);
   // Counter side
   modport cnt (input run, input tick, output count);
endinterface

// ### rtl/tsc_ro_counters.sv
// Ring oscillator event counters, untouched by the system reset
`timescale 1ns/1ps
module tsc_ro_counters
   import tsc_pkg::*;
(
   // Clock and power-on reset
   input  wire logic clk_sys_i,
   input  wire logic por_b_i,
   // Oscillator bundle
   tsc_osc_if.cnt    osc
);

   // -------------------------------------------------------------------
   // Counters
   // -------------------------------------------------------------------

   // Only power-on clears them; system reset keeps the count
   for (genvar g = 0; g < NUM_OSC; g++) begin : g_cnt
      logic [CNT_W-1:0] count;

      always_ff @(posedge clk_sys_i) begin
         if (!por_b_i) begin
            count <= OSC_CNT_RESET;
         end else if (osc.run[g] && osc.tick[g]) begin
            count <= count + 1'b1;
         end
      end

      assign osc.count[g] = count;
   end

endmodule

// ### rtl/tsc_regs.sv
// Tile status and configuration register bank on the processor-status port
//
// Behaviour
// - Core reaches every register by numbered status read and write operations.
// - Boot status is read-only; processor number in bits 23:16.
// - Boot status bits 1:0 show the sampled boot PLL mode pins.
// - Boot bit 3 boots from RAM, bit 2 from JTAG, bit 8 override.
// - Boot bit 5 shows the second core powered off.
// - Boot bit 4 tells boot code to skip OTP read-level polling.
// - Security register is loaded with the word stored in OTP.
// - Security bit 31 set makes later writes to it ignored.
// - Security bit 0 blocks debug TAP; bit 14 blocks global debug.
// - Security bits 11:8 lock one OTP sector each; bit 12 all.
// - Security bit 5 overrides boot straps, booting from OTP.
// - Security bit 4 keeps JTAG out of PLL and boot registers.
// - Four oscillators clock counters, started and stopped by control register.
// - Control bit 1 runs core oscillators, bit 0 peripheral; reset zero.
// - Counts are read-only, 16 bits, and survive system reset.
// - Counts at 0x07 tile cell, 0x08 tile wire, 0x09/0x0A peripheral.
// - Oscillators run unrelated to the tile clock; counts give random bits.
// - RAM size register is read-only, bytes in bits 31:2.
// - Debugger entry captures saved status word and program counter.
// - Status word bit 1 interrupts enabled, bit 0 events enabled.
// - Status word bit 7 fast issue, bit 6 paused waiting.
// - Status word bit 4 kernel, bit 3 interrupt handler, bit 2 enabling.
// - Status word bit 9 entry issue mode, bit 8 issue mode, bit 10 space.
`timescale 1ns/1ps
module tsc_regs
   import tsc_pkg::*;
#(
   parameter logic [31:0] RAM_BYTES = 32'h0001_0000
)
(
   // Clock and resets
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_b_i,
   input  wire logic                 por_b_i,
   // Processor-status port
   input  wire logic                 ps_req_i,
   input  wire logic                 ps_wr_i,
   input  wire logic [PS_NUM_W-1:0]  ps_num_i,
   input  wire logic [DATA_W-1:0]    ps_wdata_i,
   output logic                      ps_ack_o,
   output logic [DATA_W-1:0]         ps_rdata_o,
   // Boot status sources
   input  wire logic [7:0]           proc_num_i,
   input  wire logic [1:0]           pll_mode_pins_i,
   input  wire logic                 boot_from_ram_i,
   input  wire logic                 boot_from_jtag_i,
   input  wire logic                 core1_off_i,
   input  wire logic                 otp_skip_poll_i,
   // Security word from OTP
   input  wire logic                 otp_sec_load_i,
   input  wire logic [DATA_W-1:0]    otp_sec_word_i,
   // Ring oscillators
   input  wire logic [NUM_OSC-1:0]   ro_edge_i,
   output logic [NUM_OSC-1:0]        ro_enable_o,
   // Debugger capture
   input  wire logic                 dbg_entry_i,
   input  wire logic                 dbg_mode_i,
   input  wire logic [SSR_W-1:0]     saved_status_word_i,
   input  wire logic [DATA_W-1:0]    saved_program_counter_i,
   // Security controls
   output logic                      tap_block_o,
   output logic                      global_debug_block_o,
   output logic [SEC_SECT_W-1:0]     otp_sector_lock_o,
   output logic                      otp_redundancy_o,
   output logic                      boot_from_otp_o,
   output logic                      jtag_cfg_block_o
);

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------

   // Register-number match, shared by write and read decode
   function automatic logic hit(input logic [PS_NUM_W-1:0] num,
                                input logic [7:0]          idx);
      return num == idx;
   endfunction

   // Zero-extend a 16-bit count to a bus word
   function automatic logic [DATA_W-1:0] cnt_word(input logic [CNT_W-1:0] c);
      return {{(DATA_W-CNT_W){1'b0}}, c};
   endfunction

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   logic [DATA_W-1:0]  sec;
   logic [1:0]         osc_ctrl;
   logic [SSR_W-1:0]   dbg_ssr;
   logic [DATA_W-1:0]  dbg_spc;
   logic [BOOT_PLL_W-1:0] pll_strap;
   logic [DATA_W-1:0]  boot_status;

   tsc_osc_if osc ();

   // -------------------------------------------------------------------
   // Access decode
   // -------------------------------------------------------------------

   // Writes and reads are one-cycle requests on the status port
   wire wr_en    = ps_req_i && ps_wr_i;
   wire rd_en    = ps_req_i && !ps_wr_i;
   wire wr_sec   = wr_en && hit(ps_num_i, REG_SECURITY);
   wire wr_osc   = wr_en && hit(ps_num_i, REG_OSC_CTRL);
   // Debug registers only take software writes in debug mode
   wire wr_ssr   = wr_en && dbg_mode_i && hit(ps_num_i, REG_DBG_SSR);
   wire wr_spc   = wr_en && dbg_mode_i && hit(ps_num_i, REG_DBG_SPC);
   wire sec_lock = sec[SEC_WLOCK_BIT];

   // -------------------------------------------------------------------
   // Security configuration
   // -------------------------------------------------------------------
   logic [DATA_W-1:0] next_sec;

   // OTP copy wins over software; the lock bit freezes software writes
   always_comb begin
      next_sec = sec;
      if (otp_sec_load_i) begin
         next_sec = otp_sec_word_i & SEC_WMASK;
      end else if (wr_sec && !sec_lock) begin
         next_sec = ps_wdata_i & SEC_WMASK;
      end
   end

   // Derived security controls, named for readability
   wire [SEC_SECT_W-1:0] next_sect_lock =
      next_sec[SEC_SECT_LSB +: SEC_SECT_W] |
      {SEC_SECT_W{next_sec[SEC_ALL_BIT]}};

   // Security register and its registered control outputs
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         sec                  <= SEC_RESET;
         tap_block_o          <= SEC_RESET[SEC_TAP_BIT];
         global_debug_block_o <= SEC_RESET[SEC_GDBG_BIT];
         otp_sector_lock_o    <= SEC_RESET[SEC_SECT_LSB +: SEC_SECT_W];
         otp_redundancy_o     <= SEC_RESET[SEC_RED_BIT];
         boot_from_otp_o      <= SEC_RESET[SEC_OTPB_BIT];
         jtag_cfg_block_o     <= SEC_RESET[SEC_JCFG_BIT];
      end else begin
         sec                  <= next_sec;
         tap_block_o          <= next_sec[SEC_TAP_BIT];
         global_debug_block_o <= next_sec[SEC_GDBG_BIT];
         otp_sector_lock_o    <= next_sect_lock;
         otp_redundancy_o     <= next_sec[SEC_RED_BIT];
         boot_from_otp_o      <= next_sec[SEC_OTPB_BIT];
         jtag_cfg_block_o     <= next_sec[SEC_JCFG_BIT];
      end
   end

   // -------------------------------------------------------------------
   // Boot status
   // -------------------------------------------------------------------

   // Mode pins are caught while reset is held, then frozen
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         pll_strap <= pll_mode_pins_i;
      end
   end

   // Live image of the boot sources; reserved bits stay zero
   logic [DATA_W-1:0] next_boot;

   always_comb begin
      next_boot = '0;
      next_boot[BOOT_PLL_LSB +: BOOT_PLL_W]   = pll_strap;
      next_boot[BOOT_JTAG_BIT]                = boot_from_jtag_i;
      next_boot[BOOT_RAM_BIT]                 = boot_from_ram_i;
      next_boot[BOOT_SKIP_BIT]                = otp_skip_poll_i;
      next_boot[BOOT_C1OFF_BIT]               = core1_off_i;
      next_boot[BOOT_OVR_BIT]                 = sec[SEC_OTPB_BIT];
      next_boot[BOOT_PNUM_LSB +: BOOT_PNUM_W] = proc_num_i;
   end

   // No write path reaches this register at all
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         boot_status <= '0;
      end else begin
         boot_status <= next_boot;
      end
   end

   // -------------------------------------------------------------------
   // Ring oscillator control
   // -------------------------------------------------------------------

   // Both enables drop to zero on reset, stopping every oscillator
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         osc_ctrl <= OSC_CTRL_RESET;
      end else if (wr_osc) begin
         osc_ctrl <= ps_wdata_i[1:0];
      end
   end

   // Core pair is tile cell and wire, peripheral pair the other two
   wire [NUM_OSC-1:0] next_run = {{2{osc_ctrl[OSC_PERI_BIT]}},
                                  {2{osc_ctrl[OSC_CORE_BIT]}}};

   // Enable to the analogue rings, one cycle after the control bit
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ro_enable_o <= '0;
      end else begin
         ro_enable_o <= next_run;
      end
   end

   // Count only edges seen while the ring is enabled
   assign osc.run  = ro_enable_o;
   assign osc.tick = ro_edge_i;

   // Counter bank: reads during a run see a moving value, hence the
   // stop-and-wait discipline software keeps before reading
   tsc_ro_counters u_counters (
      .clk_sys_i (clk_sys_i),
      .por_b_i   (por_b_i),
      .osc       (osc.cnt)
   );

   // -------------------------------------------------------------------
   // Debugger capture
   // -------------------------------------------------------------------
   logic [SSR_W-1:0] next_ssr;

   // Entry capture wins over a software write in the same cycle;
   // the current issue-mode bit never takes a software value
   always_comb begin
      next_ssr = dbg_ssr;
      if (dbg_entry_i) begin
         next_ssr = saved_status_word_i;
      end else if (wr_ssr) begin
         next_ssr = (ps_wdata_i[SSR_W-1:0] & SSR_WMASK) |
                    (dbg_ssr & ~SSR_WMASK);
      end
   end

   // Saved status word, reserved bit 5 forced low
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         dbg_ssr <= SSR_RESET;
      end else begin
         dbg_ssr <= next_ssr & (SSR_WMASK | (SSR_W)'(1 << SSR_DIRO_BIT));
      end
   end

   // Saved program counter, all 32 bits debugger-writable
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         dbg_spc <= SPC_RESET;
      end else if (dbg_entry_i) begin
         dbg_spc <= saved_program_counter_i;
      end else if (wr_spc) begin
         dbg_spc <= ps_wdata_i;
      end
   end

   // -------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;

   // Unlisted numbers read as zero
   always_comb begin
      rd_mux = '0;
      if (hit(ps_num_i, REG_BOOT_STATUS)) begin
         rd_mux = boot_status;
      end else if (hit(ps_num_i, REG_SECURITY)) begin
         rd_mux = sec;
      end else if (hit(ps_num_i, REG_OSC_CTRL)) begin
         rd_mux = {30'h0000_0000, osc_ctrl};
      end else if (hit(ps_num_i, REG_TILE_CELL)) begin
         rd_mux = cnt_word(osc.count[0]);
      end else if (hit(ps_num_i, REG_TILE_WIRE)) begin
         rd_mux = cnt_word(osc.count[1]);
      end else if (hit(ps_num_i, REG_PERI_CELL)) begin
         rd_mux = cnt_word(osc.count[2]);
      end else if (hit(ps_num_i, REG_PERI_WIRE)) begin
         rd_mux = cnt_word(osc.count[3]);
      end else if (hit(ps_num_i, REG_RAM_SIZE)) begin
         rd_mux = {RAM_BYTES[DATA_W-1:RAM_SIZE_LSB], 2'h0};
      end else if (hit(ps_num_i, REG_DBG_SSR)) begin
         rd_mux = {{(DATA_W-SSR_W){1'b0}}, dbg_ssr};
      end else if (hit(ps_num_i, REG_DBG_SPC)) begin
         rd_mux = dbg_spc;
      end
   end

   // One-cycle answer; data holds until the next read
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ps_ack_o   <= 1'b0;
         ps_rdata_o <= '0;
      end else begin
         ps_ack_o <= ps_req_i;
         if (rd_en) begin
            ps_rdata_o <= rd_mux;
         end
      end
   end

endmodule

// ### sim/tsc_regs_assertions.sv
// Port-level checks for the tile status and configuration register bank
`timescale 1ns/1ps
module tsc_regs_assertions
   import tsc_pkg::*;
#(
   parameter logic [31:0] RAM_BYTES = 32'h0001_0000
)
(
   // Clock, reset and status port
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_b_i,
   input  wire logic                  ps_req_i,
   input  wire logic                  ps_wr_i,
   input  wire logic [PS_NUM_W-1:0]   ps_num_i,
   input  wire logic [DATA_W-1:0]     ps_wdata_i,
   input  wire logic                  ps_ack_o,
   input  wire logic [DATA_W-1:0]     ps_rdata_o,
   // Sources and controls
   input  wire logic [7:0]            proc_num_i,
   input  wire logic                  otp_sec_load_i,
   input  wire logic [DATA_W-1:0]     otp_sec_word_i,
   input  wire logic [NUM_OSC-1:0]    ro_enable_o,
   input  wire logic                  tap_block_o,
   input  wire logic                  global_debug_block_o,
   input  wire logic [SEC_SECT_W-1:0] otp_sector_lock_o,
   input  wire logic                  boot_from_otp_o,
   input  wire logic                  jtag_cfg_block_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   // Read strobe
   wire rd_req = ps_req_i && !ps_wr_i;

   // -------------------------------------------------------------------
   // Status port handshake and read data
   // -------------------------------------------------------------------
   AST_ACK_NEXT: assert property (ps_req_i |=> ps_ack_o)
      else $error("ack missing after request");
   AST_ACK_IDLE: assert property (!ps_req_i |=> !ps_ack_o)
      else $error("ack without request");
   AST_RDATA_HOLD: assert property (!rd_req |=> $stable(ps_rdata_o))
      else $error("read data moved without read");
   AST_BOOT_FIELDS: assert property (rd_req && ps_num_i == REG_BOOT_STATUS |=>
      ps_rdata_o[23:16] == $past(proc_num_i) && ps_rdata_o[31:24] == 8'h00
      && ps_rdata_o[15:9] == 7'h00 && ps_rdata_o[7:6] == 2'h0)
      else $error("boot status fields wrong");
   AST_RAM_SIZE: assert property (rd_req && ps_num_i == REG_RAM_SIZE |=>
      ps_rdata_o == {RAM_BYTES[31:2], 2'h0}) else $error("ram size wrong");
   AST_UNMAPPED: assert property (rd_req && ps_num_i == 8'h04 |=>
      ps_rdata_o == 32'h0000_0000) else $error("unmapped read not zero");

   // -------------------------------------------------------------------
   // Oscillator enables and security outputs
   // -------------------------------------------------------------------
   AST_OSC_WRITE: assert property (ps_req_i && ps_wr_i && ps_num_i == REG_OSC_CTRL |=>
      ##1 ro_enable_o == {{2{$past(ps_wdata_i[0], 2)}}, {2{$past(ps_wdata_i[1], 2)}}})
      else $error("oscillator enables wrong after write");
   AST_OSC_PAIRS: assert property (ro_enable_o[0] == ro_enable_o[1]
      && ro_enable_o[2] == ro_enable_o[3]) else $error("ring enables split");
   AST_OTP_DEBUG: assert property (otp_sec_load_i |=>
      tap_block_o == $past(otp_sec_word_i[0])
      && global_debug_block_o == $past(otp_sec_word_i[14]))
      else $error("debug blocks wrong after load");
   AST_OTP_LOCKS: assert property (otp_sec_load_i |=>
      otp_sector_lock_o == ($past(otp_sec_word_i[11:8]) | {4{$past(otp_sec_word_i[12])}})
      && boot_from_otp_o == $past(otp_sec_word_i[5])
      && jtag_cfg_block_o == $past(otp_sec_word_i[4]))
      else $error("sector locks wrong after load");

   // Main scenarios reached
   COV_OSC: cover property (ps_req_i && ps_wr_i && ps_num_i == REG_OSC_CTRL);
   COV_OTP: cover property (otp_sec_load_i);
   COV_SSR: cover property (rd_req && ps_num_i == REG_DBG_SSR);
endmodule

// ### sim/tsc_regs_tb.sv
// Self-checking bench for the tile status and configuration register bank
`timescale 1ns/1ps
module tsc_regs_tb;
   import tsc_pkg::*;
   localparam logic [31:0] RAM_BYTES = 32'h0002_4003;
   logic        clk_sys_i = 0, rst_b_i = 0, por_b_i = 0, ps_req_i = 0, ps_wr_i = 0;
   logic [7:0]  ps_num_i = 0, proc_num_i = 8'h5A;
   logic [31:0] ps_wdata_i = 0, otp_sec_word_i = 0, saved_program_counter_i = 0;
   logic [1:0]  pll_mode_pins_i = 2'h2;
   logic        boot_from_ram_i = 0, boot_from_jtag_i = 0, core1_off_i = 0;
   logic        otp_skip_poll_i = 0, otp_sec_load_i = 0, dbg_entry_i = 0, dbg_mode_i = 0;
   logic [3:0]  ro_edge_i = 0, ro_enable_o, otp_sector_lock_o;
   logic [10:0] saved_status_word_i = 0;
   logic        ps_ack_o, tap_block_o, global_debug_block_o, otp_redundancy_o;
   logic        boot_from_otp_o, jtag_cfg_block_o;
   logic [31:0] ps_rdata_o, seed = 32'hED58DFF7, w;
   logic [32:0] exp_q[$], ne;
   logic [15:0] cnt[4] = '{default: 16'h0000};
   int          n_errors = 0, comparisons = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   tsc_regs #(.RAM_BYTES(RAM_BYTES)) tsc_regs_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .por_b_i(por_b_i), .ps_req_i(ps_req_i), .ps_wr_i(ps_wr_i), .ps_num_i(ps_num_i),
      .ps_wdata_i(ps_wdata_i), .ps_ack_o(ps_ack_o), .ps_rdata_o(ps_rdata_o),
      .proc_num_i(proc_num_i), .pll_mode_pins_i(pll_mode_pins_i),
      .boot_from_ram_i(boot_from_ram_i), .boot_from_jtag_i(boot_from_jtag_i),
      .core1_off_i(core1_off_i), .otp_skip_poll_i(otp_skip_poll_i),
      .otp_sec_load_i(otp_sec_load_i), .otp_sec_word_i(otp_sec_word_i),
      .ro_edge_i(ro_edge_i), .ro_enable_o(ro_enable_o), .dbg_entry_i(dbg_entry_i),
      .dbg_mode_i(dbg_mode_i), .saved_status_word_i(saved_status_word_i),
      .saved_program_counter_i(saved_program_counter_i), .tap_block_o(tap_block_o),
      .global_debug_block_o(global_debug_block_o), .otp_sector_lock_o(otp_sector_lock_o),
      .otp_redundancy_o(otp_redundancy_o), .boot_from_otp_o(boot_from_otp_o),
      .jtag_cfg_block_o(jtag_cfg_block_o));

   // Galois step, used for every random value
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h0440_0007 : 32'h0);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One access, entered at a rising edge; reads queue their expectation
   task automatic acc(input logic wr, input logic [7:0] num, input logic [31:0] wd,
                      input logic [31:0] exp);
      exp_q.push_back({!wr, exp});
      ps_req_i <= 1'b1;
      ps_wr_i <= wr;
      ps_num_i <= num;
      ps_wdata_i <= wd;
      @(posedge clk_sys_i);
      ps_req_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
   endtask

   // Security-driven outputs against a register image
   task automatic sec_outs(input logic [31:0] s);
      check({global_debug_block_o, tap_block_o, otp_redundancy_o, otp_sector_lock_o,
             boot_from_otp_o, jtag_cfg_block_o}, {s[14], s[0], s[7],
             s[11:8] | {4{s[12]}}, s[5], s[4]});
   endtask

   task automatic otp_load(input logic [31:0] s);
      otp_sec_word_i <= s;
      otp_sec_load_i <= 1'b1;
      @(posedge clk_sys_i);
      otp_sec_load_i <= 1'b0;
      @(posedge clk_sys_i);
      sec_outs(s);
      acc(0, REG_SECURITY, 0, s & SEC_WMASK);
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Monitor: each acknowledge retires the oldest note
   always @(posedge clk_sys_i) begin
      if (ps_ack_o === 1'b1) begin
         if (exp_q.size() == 0)
            check(32'h0000_0001, 32'h0000_0000);
         else begin
            ne = exp_q.pop_front();
            if (ne[32])
               check(ps_rdata_o, ne[31:0]);
         end
      end
   end

   // Watchdog well past the expected run of about 250 cycles
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      n_errors++;
      wrap_up();
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      por_b_i <= 1'b1;
      pll_mode_pins_i <= 2'h1;
      @(posedge clk_sys_i);
      // Reset values, counters, ram size and an unmapped number
      foreach (cnt[k]) acc(0, REG_TILE_CELL + 8'(k), 0, 32'h0);
      acc(0, REG_OSC_CTRL, 0, 32'h0);
      acc(0, 8'h04, 0, 32'h0);
      acc(0, REG_RAM_SIZE, 0, RAM_BYTES & 32'hFFFF_FFFC);
      // Every boot level combination; pins keep their sample from reset
      for (int i = 0; i < 16; i++) begin
         {core1_off_i, otp_skip_poll_i, boot_from_ram_i, boot_from_jtag_i} <= 4'(i);
         @(posedge clk_sys_i); // Image lags the pins
         acc(0, REG_BOOT_STATUS, 0, {16'h005A, 10'h0, 4'(i), 2'h2});
      end
      acc(1, REG_BOOT_STATUS, 32'hFFFF_FFFF, 0);
      acc(0, REG_BOOT_STATUS, 0, {16'h005A, 10'h0, 4'hF, 2'h2});
      // Security: load, write and lock, ignored write, load past the lock
      seed = lfsr(seed);
      otp_load(seed & 32'h7FFF_FFFF);
      seed = lfsr(seed);
      w = seed | 32'h8000_0020;
      acc(1, REG_SECURITY, w, 0);
      sec_outs(w);
      acc(0, REG_SECURITY, 0, w & SEC_WMASK);
      acc(0, REG_BOOT_STATUS, 0, {16'h005A, 7'h0, 1'b1, 2'h0, 4'hF, 2'h2});
      acc(1, REG_SECURITY, ~w, 0);
      acc(0, REG_SECURITY, 0, w & SEC_WMASK);
      otp_load(~w);
      // Oscillators: all running on random edges, then peripheral only
      acc(1, REG_OSC_CTRL, 32'hFFFF_FFFF, 0);
      acc(0, REG_OSC_CTRL, 0, 32'h3);
      check(ro_enable_o, 4'hF);
      for (int n = 0; n < 40; n++) begin
         seed = lfsr(seed);
         ro_edge_i <= seed[3:0];
         foreach (cnt[k]) cnt[k] += 16'(seed[k]);
         @(posedge clk_sys_i);
      end
      ro_edge_i <= 4'h0;
      acc(1, REG_OSC_CTRL, 32'h1, 0);
      check(ro_enable_o, 4'hC);
      ro_edge_i <= 4'hF;
      repeat (6) @(posedge clk_sys_i);
      ro_edge_i <= 4'h0;
      cnt[2] += 16'd6;
      cnt[3] += 16'd6;
      acc(1, REG_OSC_CTRL, 32'h0, 0);
      repeat (10) @(posedge clk_sys_i);
      foreach (cnt[k]) acc(0, REG_TILE_CELL + 8'(k), 0, {16'h0, cnt[k]});
      // System reset with the oscillators stopped: counts survive, pins resampled
      rst_b_i <= 1'b0;
      pll_mode_pins_i <= 2'h3;
      repeat (4) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      @(posedge clk_sys_i);
      sec_outs(32'h0);
      acc(0, REG_BOOT_STATUS, 0, {16'h005A, 10'h0, 4'hF, 2'h3});
      foreach (cnt[k]) acc(0, REG_TILE_CELL + 8'(k), 0, {16'h0, cnt[k]});
      // Debug capture, gated writes, masked writes in debug mode
      seed = lfsr(seed);
      saved_status_word_i <= seed[10:0];
      saved_program_counter_i <= lfsr(seed);
      dbg_entry_i <= 1'b1;
      @(posedge clk_sys_i);
      dbg_entry_i <= 1'b0;
      acc(0, REG_DBG_SSR, 0, {21'h0, seed[10:0] & 11'h7DF});
      acc(1, REG_DBG_SPC, 32'h1234_5678, 0);
      acc(0, REG_DBG_SPC, 0, lfsr(seed));
      dbg_mode_i <= 1'b1;
      acc(1, REG_DBG_SSR, 32'hFFFF_FFFF, 0);
      acc(0, REG_DBG_SSR, 0, {21'h0, (seed[10:0] & 11'h100) | 11'h6DF});
      acc(1, REG_DBG_SPC, 32'hC0DE_0042, 0);
      acc(0, REG_DBG_SPC, 0, 32'hC0DE_0042);
      repeat (3) @(posedge clk_sys_i);
      check(32'(exp_q.size()), 32'h0);
      wrap_up();
   end
endmodule

bind tsc_regs tsc_regs_assertions #(.RAM_BYTES(RAM_BYTES)) tsc_regs_assertions_i (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ps_req_i(ps_req_i), .ps_wr_i(ps_wr_i),
   .ps_num_i(ps_num_i), .ps_wdata_i(ps_wdata_i), .ps_ack_o(ps_ack_o),
   .ps_rdata_o(ps_rdata_o), .proc_num_i(proc_num_i), .otp_sec_load_i(otp_sec_load_i),
   .otp_sec_word_i(otp_sec_word_i), .ro_enable_o(ro_enable_o), .tap_block_o(tap_block_o),
   .global_debug_block_o(global_debug_block_o), .otp_sector_lock_o(otp_sector_lock_o),
   .boot_from_otp_o(boot_from_otp_o), .jtag_cfg_block_o(jtag_cfg_block_o));
